// >>> crx_pkg.sv
/*
  Shared constants and types of the crossbar path control block.
  Assumes 8-bit register offsets reached over a two-wire serial slave.
*/
package crx_pkg;
  // Register offsets
  localparam logic [7:0] REG_SYSTEM_CONTROL = 8'h01;
  localparam logic [7:0] REG_ROUTE1 = 8'h02;
  localparam logic [7:0] REG_ROUTE2 = 8'h03;
  localparam logic [7:0] REG_ROUTE3 = 8'h04;
  localparam logic [7:0] REG_ROUTE4 = 8'h05;
  localparam logic [7:0] REG_SIDEBAND_SEL = 8'h06;
  localparam logic [7:0] REG_CROSS5_CTRL = 8'h07;
  localparam logic [7:0] REG_REVISION = 8'h09;
  // Field positions
  localparam int MODE_BIT = 7;
  localparam int LOW_GRP_POS = 0;
  localparam int HIGH_GRP_POS = 3;
  localparam int SB_SEL_POS = 6;
  localparam int XBAR_POS = 0;
  // Reset values
  localparam logic MODE_RESET = 1'b0;
  localparam logic [2:0] HS_SEL_RESET = 3'h0;
  localparam logic [1:0] SB_SEL_RESET = 2'h0;
  localparam logic [1:0] XBAR_RESET = 2'h1;
  // Sizes
  localparam int NUM_HS = 4;
  localparam int HS_INPUTS = 3;
  localparam int SYNC_W = 3;
  // Serial slave address: 7-bit base, select pins land on bits 2:1
  localparam logic [6:0] DEV_ADDR_BASE = 7'h30;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_OFFSET, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
  } crx_i2c_state_t;
endpackage

// >>> crx_bus_if.sv
/*
  Register access path between the serial slave and the register file.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface crx_bus_if;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  modport slave (output wr_stb, output wr_addr, output wr_data,
                 output rd_addr, input rd_data);
  modport regs (input wr_stb, input wr_addr, input wr_data,
                input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> crx_i2c_slave.sv
/*
  Two-wire serial slave: address match, register offset, auto-increment.
  Assumes SCL and SDA are asynchronous pins; the core clock oversamples
  them many times per bit. No clock stretching is done.
*/
`timescale 1ns/1ns
`default_nettype none
module crx_i2c_slave
  import crx_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] dev_addr_in,
  output logic sda_oe_n_out,
  crx_bus_if.slave bus
);
  logic [SYNC_W-1:0] scl_q, scl_d, sda_q, sda_d;
  crx_i2c_state_t st_q, st_d, ret_q, ret_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, off_q, off_d;
  logic drv_q, drv_d, wr_q, wr_d;
  logic oe_n_q, oe_n_d;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Bit 0 feeds only bit 1; edges come from bits 1 and 2
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_c = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_c = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  assign bus.wr_stb = wr_q;
  assign bus.wr_addr = off_q;
  assign bus.wr_data = sh_q;
  assign bus.rd_addr = off_q;
  assign sda_oe_n_out = oe_n_q; // Pin enable comes straight off a flop

  // Protocol engine; start and stop override any state
  always_comb begin
    scl_d = {scl_q[SYNC_W-2:0], scl_in};
    sda_d = {sda_q[SYNC_W-2:0], sda_in};
    st_d = st_q;
    ret_d = ret_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    off_d = off_q;
    drv_d = drv_q;
    wr_d = 1'b0;
    if (wr_q) begin
      off_d = off_q + 8'h01;
    end
    if (start_c) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
        end
        ST_ADDR, ST_OFFSET, ST_WDATA: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            st_d = ST_ACK;
            drv_d = 1'b1;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] == dev_addr_in) begin
                ret_d = sh_q[0] ? ST_RDATA : ST_OFFSET;
              end else begin
                st_d = ST_IDLE; // Not ours: stay silent
                drv_d = 1'b0;
              end
            end else if (st_q == ST_OFFSET) begin
              off_d = sh_q;
              ret_d = ST_WDATA;
            end else begin
              wr_d = 1'b1;
              ret_d = ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_d = ret_q;
            drv_d = 1'b0;
            if (ret_q == ST_RDATA) begin
              sh_d = bus.rd_data;
              drv_d = ~bus.rd_data[7];
              cnt_d = 4'h0;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == LAST_BIT) begin
              drv_d = 1'b0;
              st_d = ST_RACK;
              cnt_d = 4'h0;
              off_d = off_q + 8'h01;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_q[1]) begin
            st_d = ST_IDLE; // Master ended the read
          end else if (scl_fall) begin
            st_d = ST_RDATA;
            sh_d = bus.rd_data;
            drv_d = ~bus.rd_data[7];
            cnt_d = 4'h0;
          end
        end
      endcase
    end
    // Enable kept active low in its own flop, no inverter on the pin
    oe_n_d = ~drv_d;
  end

  // Protocol registers; SDA idles released
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= '1;
      sda_q <= '1;
      st_q <= ST_IDLE;
      ret_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      off_q <= 8'h00;
      drv_q <= 1'b0;
      wr_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      st_q <= st_d;
      ret_q <= ret_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      off_q <= off_d;
      drv_q <= drv_d;
      wr_q <= wr_d;
      oe_n_q <= oe_n_d;
    end
  end

  a_offset_wrap: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    wr_q && !start_c |=> off_q == 8'($past(off_q) + 8'h01))
    else $error("offset did not advance after a write");

  a_addr_match: assert property (
    @(posedge core_clk_in) disable iff (!resetn_in)
    (st_q == ST_ADDR && st_d == ST_ACK) |-> sh_q[7:1] == dev_addr_in)
    else $error("acknowledged a foreign slave address");
endmodule
`default_nettype wire

// >>> crx_switch_ctrl.sv
/*
  Path control of a passive crossbar: four 3:1 high-speed selects and a
  sideband 2:1 select with straight or swapped crossbar, set over a
  two-wire serial slave. Assumes the analog switches sit outside and
  treat an all-zero select as high impedance.
*/
`timescale 1ns/1ns
`default_nettype none
module crx_switch_ctrl
  import crx_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5A // Arbitrary value
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic path_enable_pin_in,
  input wire logic address_select_pin_low_in,
  input wire logic address_select_pin_high_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic [NUM_HS-1:0][HS_INPUTS-1:0] hs_route_out,
  output logic [1:0] sb_input_sel_out,
  output logic [1:0] sb_xbar_out,
  output logic standby_out
);
  crx_bus_if bus ();
  logic [2:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
  logic path_en_s;
  logic mode_q, mode_d;
  logic [HS_INPUTS-1:0] op_sel_q [NUM_HS];
  logic [HS_INPUTS-1:0] op_sel_d [NUM_HS];
  logic [1:0] sb_sel_q, sb_sel_d, xbar_q, xbar_d;
  logic [3:0] sb_q, sb_d, sb_want;
  logic gate_c, sda_level_q, standby_d;
  logic [6:0] dev_addr;

  assign path_en_s = pin_s2_q[0];
  assign gate_c = path_en_s & mode_q;
  // Pin pair steps the 7-bit address by two, 8-bit pair by four
  assign dev_addr = DEV_ADDR_BASE | {4'h0, pin_s2_q[2:1], 1'b0};

  crx_i2c_slave u_slave (
    .core_clk_in (core_clk_in),
    .resetn_in (resetn_in),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .dev_addr_in (dev_addr),
    .sda_oe_n_out (sda_oe_n_out),
    .bus (bus.slave)
  );

  // Two-stage sync of enable and address-select pins
  always_comb begin
    pin_s1_d = {address_select_pin_high_in, address_select_pin_low_in,
                path_enable_pin_in};
    pin_s2_d = pin_s1_q;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      sda_level_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      sda_level_q <= 1'b0; // Open drain: only ever pulls low
    end
  end
  assign sda_out = sda_level_q;

  // Register writes; reserved bits are dropped. Enable pin never touches
  // this state, so routing survives a low pulse on it.
  always_comb begin
    mode_d = mode_q;
    op_sel_d = op_sel_q;
    sb_sel_d = sb_sel_q;
    xbar_d = xbar_q;
    if (bus.wr_stb) begin
      case (bus.wr_addr)
        REG_SYSTEM_CONTROL: mode_d = bus.wr_data[MODE_BIT];
        REG_ROUTE1: op_sel_d[0] = bus.wr_data[LOW_GRP_POS +: HS_INPUTS];
        REG_ROUTE2: op_sel_d[1] = bus.wr_data[LOW_GRP_POS +: HS_INPUTS];
        REG_ROUTE3: op_sel_d[2] = bus.wr_data[HIGH_GRP_POS +: HS_INPUTS];
        REG_ROUTE4: op_sel_d[3] = bus.wr_data[HIGH_GRP_POS +: HS_INPUTS];
        REG_SIDEBAND_SEL: sb_sel_d = bus.wr_data[SB_SEL_POS +: 2];
        REG_CROSS5_CTRL: xbar_d = bus.wr_data[XBAR_POS +: 2];
        default: begin
        end
      endcase
    end
  end

  // Settings come up cleared except the crossbar field at 1; mode off keeps every path open
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= MODE_RESET;
      for (int i = 0; i < NUM_HS; i++) begin
        op_sel_q[i] <= HS_SEL_RESET;
      end
      sb_sel_q <= SB_SEL_RESET;
      xbar_q <= XBAR_RESET;
    end else begin
      mode_q <= mode_d;
      op_sel_q <= op_sel_d;
      sb_sel_q <= sb_sel_d;
      xbar_q <= xbar_d;
    end
  end

  // Read mux; every offset answers, unmapped ones read zero
  always_comb begin
    bus.rd_data = 8'h00;
    case (bus.rd_addr)
      REG_SYSTEM_CONTROL: bus.rd_data[MODE_BIT] = mode_q;
      REG_ROUTE1: bus.rd_data[LOW_GRP_POS +: HS_INPUTS] = op_sel_q[0];
      REG_ROUTE2: bus.rd_data[LOW_GRP_POS +: HS_INPUTS] = op_sel_q[1];
      REG_ROUTE3: bus.rd_data[HIGH_GRP_POS +: HS_INPUTS] = op_sel_q[2];
      REG_ROUTE4: bus.rd_data[HIGH_GRP_POS +: HS_INPUTS] = op_sel_q[3];
      REG_SIDEBAND_SEL: bus.rd_data[SB_SEL_POS +: 2] = sb_sel_q;
      REG_CROSS5_CTRL: bus.rd_data[XBAR_POS +: 2] = xbar_q;
      REG_REVISION: bus.rd_data = REVISION_ID;
      default: bus.rd_data = 8'h00;
    endcase
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // One select path per high-speed output, each on its own
  for (genvar g = 0; g < NUM_HS; g++) begin : g_hs
    logic [HS_INPUTS-1:0] want, nxt;
    always_comb begin
      want = (gate_c && $onehot(op_sel_q[g])) ? op_sel_q[g] : '0;
      // Open for one cycle before closing a different input
      nxt = (hs_route_out[g] != '0 && want != hs_route_out[g]) ? '0 : want;
    end
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        hs_route_out[g] <= '0;
      end else begin
        hs_route_out[g] <= nxt;
      end
    end

    a_hs_onehot: assert property ($onehot0(hs_route_out[g]))
      else $error("high-speed output joined to several inputs");
    a_hs_bbm: assert property (
      (hs_route_out[g] != '0) && ($past(hs_route_out[g]) != '0)
      |-> hs_route_out[g] == $past(hs_route_out[g]))
      else $error("high-speed path switched without a break");
  end

  // Sideband: input pair select then straight or swapped crossbar
  always_comb begin
    sb_want = (gate_c && $onehot(sb_sel_q) && $onehot(xbar_q))
              ? {sb_sel_q, xbar_q} : 4'h0;
    sb_d = (sb_q != 4'h0 && sb_want != sb_q) ? 4'h0 : sb_want;
    standby_d = ~gate_c;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sb_q <= 4'h0;
      standby_out <= 1'b1;
    end else begin
      sb_q <= sb_d;
      standby_out <= standby_d;
    end
  end
  assign sb_input_sel_out = sb_q[3:2];
  assign sb_xbar_out = sb_q[1:0];

  sequence s_pin_back;
    $rose(path_en_s) && mode_q && $onehot(op_sel_q[0]) && !bus.wr_stb
    ##1 !bus.wr_stb;
  endsequence

  a_pin_off_hiz: assert property (
    !path_en_s |=> hs_route_out == '0 && sb_q == 4'h0)
    else $error("output routed while enable pin low");
  a_mode_off_hiz: assert property (
    !mode_q |=> hs_route_out == '0 && sb_q == 4'h0 && standby_out)
    else $error("output routed in shutdown mode");
  a_regs_kept: assert property (
    !path_en_s && !bus.wr_stb |=> $stable(mode_q) && $stable(op_sel_q[0])
    && $stable(xbar_q))
    else $error("settings changed while enable pin low");
  a_pin_restore: assert property (
    s_pin_back |-> hs_route_out[0] == op_sel_q[0])
    else $error("routing not restored after enable pin rose");
  a_sb_shape: assert property (
    sb_q != 4'h0 |-> $onehot(sb_q[3:2]) && $onehot(sb_q[1:0]))
    else $error("sideband select or crossbar not one-hot");
endmodule
`default_nettype wire

// >>> crx_host_model.sv
/*
  Serial bus host model that drives the block's two-wire slave port.
  Assumes a pull-up on the data line and an 80 ns bit period.
*/
`timescale 1ns/1ns
`default_nettype none
module crx_host_model (
  input wire logic dev_oe_n_in,
  output logic scl_out,
  output logic sda_out
);
  localparam int HALF = 40;
  logic host_low;
  // Open-drain wire: either party pulls low, else pull-up wins
  assign sda_out = (host_low || !dev_oe_n_in) ? 1'b0 : 1'b1;
  // Bus idles released, clock stands high between frames
  initial begin
    host_low = 1'b0;
    scl_out = 1'b1;
  end
  // Data moves late in the low phase so the slave never sees a false start
  task automatic bit_io(input logic b, output logic r);
    #30;
    host_low = !b;
    #10;
    scl_out = 1'b1;
    r = sda_out;
    #HALF;
    scl_out = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    #30;
    host_low = 1'b0;
    #10;
    scl_out = 1'b1;
    #HALF;
    host_low = 1'b1;
    #HALF;
    scl_out = 1'b0;
  endtask
  task automatic stop();
    #30;
    host_low = 1'b1;
    #10;
    scl_out = 1'b1;
    #HALF;
    host_low = 1'b0;
    #HALF;
  endtask
  // Byte out, MSB first; ack is true when the slave pulled low
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  // Burst write; data is only sent if the address was acknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] off,
                    input logic [7:0] d[$], output logic ack);
    logic k;
    start();
    send({a, 1'b0}, ack);
    if (ack) begin
      send(off, k);
      foreach (d[i]) send(d[i], k);
    end
    stop();
  endtask
  // Offset write, repeated start, one byte read closed by a NACK
  task automatic rd(input logic [6:0] a, input logic [7:0] off,
                    output logic [7:0] v);
    logic k;
    start();
    send({a, 1'b0}, k);
    send(off, k);
    start();
    send({a, 1'b1}, k);
    recv(1'b1, v);
    stop();
  endtask
  // Two-byte read: host acks the first byte, NACKs the second
  task automatic rd2(input logic [6:0] a, input logic [7:0] off,
                     output logic [7:0] v, output logic [7:0] w);
    logic k;
    start();
    send({a, 1'b0}, k);
    send(off, k);
    start();
    send({a, 1'b1}, k);
    recv(1'b0, v);
    recv(1'b1, w);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> crossbar_switch_path_control_test.sv
/*
  Self-checking bench of the crossbar path control block.
  Assumes the host model file is compiled first; 125 MHz core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module crossbar_switch_path_control_test;
  import crx_pkg::*;
  logic clk, resetn, en_pin, a_lo, a_hi, scl, sda, sda_oe_n, standby, ack;
  logic sda_lvl;
  logic [NUM_HS-1:0][HS_INPUTS-1:0] hs_route;
  logic [1:0] sb_sel, sb_xbar;
  logic [6:0] dev_addr;
  logic [7:0] v, w;
  logic [7:0] regs [8];
  logic [7:0] mask [10] = '{8'h00, 8'h80, 8'h07, 8'h07, 8'h38, 8'h38,
                            8'hC0, 8'h03, 8'h00, 8'h5A};
  int mismatches, num_checks;
  crx_switch_ctrl uut (.core_clk_in(clk), .resetn_in(resetn),
    .path_enable_pin_in(en_pin), .address_select_pin_low_in(a_lo),
    .address_select_pin_high_in(a_hi), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_lvl), .sda_oe_n_out(sda_oe_n), .hs_route_out(hs_route),
    .sb_input_sel_out(sb_sel), .sb_xbar_out(sb_xbar),
    .standby_out(standby));
  crx_host_model host (.dev_oe_n_in(sda_oe_n), .scl_out(scl),
    .sda_out(sda));
  always #4 clk = ~clk;
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Expected high-speed select: one-hot field only, gated by pin and mode
  function automatic logic [2:0] exp_hs(int i);
    logic [2:0] f;
    f = (i < 2) ? regs[2 + i][2:0] : regs[2 + i][5:3];
    return (en_pin && regs[1][7] && $countones(f) == 1) ? f : 3'h0;
  endfunction
  // Sideband needs both the pair select and the crossbar one-hot
  function automatic logic [3:0] exp_sb();
    logic ok;
    ok = $countones(regs[6][7:6]) == 1 && $countones(regs[7][1:0]) == 1;
    return (ok && en_pin && regs[1][7]) ? {regs[7][1:0], regs[6][7:6]} : 4'h0;
  endfunction
  // Path outputs settle a few clocks after the stop condition
  task automatic check_out();
    repeat (6) @(posedge clk);
    #1;
    for (int i = 0; i < NUM_HS; i++) chk("hs_route", hs_route[i], exp_hs(i));
    chk("sideband", {sb_xbar, sb_sel}, exp_sb());
    chk("standby", standby, !(en_pin && regs[1][7]));
    chk("sda_level", sda_lvl, 1'b0);
  endtask
  task automatic put(input logic [7:0] off, input logic [7:0] val);
    host.wr(dev_addr, off, '{val}, ack);
    chk("ack", ack, 1'b1);
    if (off < 8) regs[off[2:0]] = val;
    check_out();
  endtask
  // Inputs move one step after the rising edge
  task automatic pins(input logic e);
    @(posedge clk);
    #1 en_pin = e;
  endtask
  initial begin
    #600000;
    mismatches++;
    end_of_test();
  end
  initial begin
    void'($urandom(35));
    clk = 1'b0;
    resetn = 1'b0;
    en_pin = 1'b0;
    {a_hi, a_lo} = 2'h0;
    regs = '{default: 8'h00};
    regs[7] = 8'h01;
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    check_out();
    // Each select-pin setting: own address acked, a neighbour refused
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      #1 {a_hi, a_lo} = 2'(p);
      repeat (4) @(posedge clk);
      #1;
      dev_addr = 7'h30 | 7'(p << 1);
      host.wr(dev_addr, REG_SYSTEM_CONTROL, '{8'h00}, ack);
      chk("own_addr", ack, 1'b1);
      host.wr(dev_addr ^ 7'h02, REG_SYSTEM_CONTROL, '{8'h80}, ack);
      chk("other_addr", ack, 1'b0);
    end
    pins(1'b1);
    check_out();
    // Burst over the top offset wraps to zero, then sets the mode bit
    host.wr(dev_addr, 8'hFF, '{8'h80, 8'h80, 8'h80}, ack);
    chk("wrap_ack", ack, 1'b1);
    regs[1] = 8'h80;
    check_out();
    // Every select pattern on every high-speed output
    for (int i = 0; i < NUM_HS; i++)
      for (int k = 0; k < 8; k++)
        put(8'(2 + i), 8'(k << ((i < 2) ? 0 : 3)));
    // Every sideband select against every crossbar pattern
    for (int s = 0; s < 4; s++)
      for (int x = 0; x < 4; x++) begin
        put(REG_SIDEBAND_SEL, 8'(s << 6));
        put(REG_CROSS5_CTRL, 8'(x));
      end
    // Whole routing set in one burst
    host.wr(dev_addr, REG_ROUTE1, '{8'h01, 8'h04, 8'h10, 8'h08}, ack);
    chk("burst_ack", ack, 1'b1);
    regs[2] = 8'h01;
    regs[3] = 8'h04;
    regs[4] = 8'h10;
    regs[5] = 8'h08;
    check_out();
    // Random writes with enable pin toggling in between
    for (int n = 0; n < 24; n++) begin
      put(8'(2 + $urandom % 6), 8'($urandom));
      pins(1'($urandom));
      check_out();
    end
    pins(1'b1);
    put(REG_SYSTEM_CONTROL, 8'hFF);
    // Burst read: offset advances between the two bytes
    host.rd2(dev_addr, REG_SIDEBAND_SEL, v, w);
    chk("burst_rd0", v, regs[6] & mask[6]);
    chk("burst_rd1", w, regs[7] & mask[7]);
    // Read back: reserved bits zero, revision, ignored offsets zero
    for (int o = 1; o < 11; o++) begin
      host.rd(dev_addr, 8'(o), v);
      chk("readback", v, (o < 8) ? (regs[o] & mask[o]) :
          (o < 10) ? mask[o] : 8'h00);
    end
    put(REG_SYSTEM_CONTROL, 8'h00);
    check_out();
    end_of_test();
  end
endmodule
`default_nettype wire
